// ===== hdl/posc_cfg_decode.sv
// Decoder that turns the raw configuration fields into the values the timing datapath uses.
`timescale 1ns/1ps
module posc_cfg_decode (
  posc_cfg_if.decode cfg
);
  import posc_pkg::*;

  // ----------------------------------------------------------------
  // Combinational decode.
  // ----------------------------------------------------------------

  // The offset is a signed count of 0.61 ns steps; only a master honours the enable.
  always_comb begin
    if (cfg.masterMode && !cfg.phaseShiftEnable) begin
      cfg.appliedOffset = 11'sh000; // R3
    end else begin
      cfg.appliedOffset = {cfg.phaseShiftValue[9], cfg.phaseShiftValue}; // R1
    end
  end

  // Alarm limit in unit intervals is the code plus one.
  assign cfg.alarmLimitUi = {1'b0, cfg.alarmLimitCode} + 4'h1; // R4

  // Sample shift in half unit intervals; positive means late.
  always_comb begin
    unique case (posc_sample_t'(cfg.samplePointCode))
      POSC_SMP_ON_TARGET: cfg.sampleShiftHalfUi = 3'sh0; // R6
      POSC_SMP_HALF_EARLY: cfg.sampleShiftHalfUi = -3'sh1; // R6
      POSC_SMP_ONE_LATE: cfg.sampleShiftHalfUi = 3'sh2; // R6
      POSC_SMP_HALF_LATE: cfg.sampleShiftHalfUi = 3'sh1; // R6
    endcase
  end

endmodule : posc_cfg_decode

// ===== hdl/posc_cfg_if.sv
// Interface that carries the live configuration from the register bank to the decode module.
`timescale 1ns/1ps
interface posc_cfg_if;
  logic [9:0] phaseShiftValue;
  logic phaseShiftEnable;
  logic masterMode;
  logic [2:0] alarmLimitCode;
  logic [1:0] samplePointCode;
  logic signed [10:0] appliedOffset;
  logic [3:0] alarmLimitUi;
  logic signed [2:0] sampleShiftHalfUi;

  modport bank (output phaseShiftValue, phaseShiftEnable, masterMode, alarmLimitCode, samplePointCode,
                input appliedOffset, alarmLimitUi, sampleShiftHalfUi);
  modport decode (input phaseShiftValue, phaseShiftEnable, masterMode, alarmLimitCode, samplePointCode,
                  output appliedOffset, alarmLimitUi, sampleShiftHalfUi);
endinterface : posc_cfg_if

// ===== hdl/posc_pkg.sv
// Package of register offsets, field layouts, reset values and timing constants for the phase/sync config bank.
package posc_pkg;

  // ----------------------------------------------------------------
  // Register word indices; byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PHASE_LOW = 8'h7A;
  localparam logic [7:0] IDX_PHASE_HIGH = 8'h7B;
  localparam logic [7:0] IDX_ALARM_LIMIT = 8'h7C;
  localparam logic [7:0] IDX_SAMPLE_POINT = 8'h7D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h7E;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7F;
  localparam logic [7:0] IDX_DEVICE_CTRL = 8'h80;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int PH_HI_LSB = 0;
  localparam int PH_EN_BIT = 7;
  localparam int LIM_LSB = 4;
  localparam int FILL_LSB = 0;
  localparam int SMP_LSB = 0;
  localparam int MASTER_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and fixed patterns.
  // ----------------------------------------------------------------
  localparam logic [7:0] PH_LOW_RST = 8'h00;
  localparam logic [1:0] PH_HIGH_RST = 2'h0;
  localparam logic PH_EN_RST = 1'b0;
  localparam logic [2:0] LIM_RST = 3'h2;
  localparam logic [3:0] LIM_FILL = 4'hB;
  localparam logic [1:0] SMP_RST = 2'h0;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // Interrupt event bits.
  localparam int EV_PHASE = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_SAMPLE = 2;
  localparam int EV_FILL = 3;

  // ----------------------------------------------------------------
  // Timing: phase step in picoseconds per count, and slave answer latency.
  // ----------------------------------------------------------------
  localparam int PHASE_STEP_PS = 610;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int BUS_WAIT_CYCLES = 1;

  // Sampling point selection.
  typedef enum logic [1:0] {
    POSC_SMP_ON_TARGET = 2'h0,
    POSC_SMP_HALF_EARLY = 2'h1,
    POSC_SMP_ONE_LATE = 2'h2,
    POSC_SMP_HALF_LATE = 2'h3
  } posc_sample_t;

endpackage : posc_pkg

// ===== hdl/posc_regs.sv
// Avalon-MM register bank for phase offset and external sync settings, with interrupt status.
// Behaviour
// R1 - Phase shift is ten-bit signed; offset equals value times 0.61 ns.
// R2 - Low eight bits in first register; upper two in bits 1..0 of next.
// R3 - As master, offset applies only while enable bit 7 is one; resets zero.
// R4 - Three-bit alarm limit codes 0..7 mean plus/minus 1..8 UI; default 3.
// R5 - Software writes 1011 into the alarm register's low four bits.
// R6 - Two-bit sample code: on target, half early, one late, half late.
// R7 - Software writes zeros to reserved bits and ignores them on read.
`timescale 1ns/1ps
module posc_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [posc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  output logic signed [10:0] appliedOffset,
  output logic [3:0] alarmLimitUi,
  output logic signed [2:0] sampleShiftHalfUi
);
  import posc_pkg::*;

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------
  logic [7:0] phaseLow_q, phaseLow_d;
  logic [1:0] phaseHigh_q, phaseHigh_d;
  logic phaseEn_q, phaseEn_d;
  logic [2:0] alarmLimit_q, alarmLimit_d;
  logic [3:0] alarmFill_q, alarmFill_d;
  logic [1:0] samplePoint_q, samplePoint_d;
  logic masterMode_q, masterMode_d;
  logic [3:0] irqStatus_q, irqStatus_d;
  logic [3:0] irqMask_q, irqMask_d;
  logic [31:0] readdata_q, readdata_d;
  logic waitrequest_q, waitrequest_d;
  logic irq_q, irq_d;
  logic signed [10:0] offset_q;
  logic [3:0] limitUi_q;
  logic signed [2:0] shift_q;
  logic [3:0] events;
  logic accessDone;
  logic [7:0] wordIndex;
  logic addrHit;

  posc_cfg_if cfgBus ();

  // Word index from the byte address; low two bits select a byte lane only.
  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : word_of

  // ----------------------------------------------------------------
  // Bus handshake.
  // ----------------------------------------------------------------

  // One wait cycle per access keeps read data registered: the request is taken when waitrequest is low.
  assign accessDone = (read || write) && !waitrequest_q;
  assign wordIndex = word_of(address);
  assign addrHit = (wordIndex >= IDX_PHASE_LOW) && (wordIndex <= IDX_DEVICE_CTRL);

  always_comb begin
    waitrequest_d = 1'b1;
    if ((read || write) && waitrequest_q) begin
      waitrequest_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and event detection.
  // ----------------------------------------------------------------

  // Only byte lane zero carries data; writes without it are ignored.
  always_comb begin
    phaseLow_d = phaseLow_q;
    phaseHigh_d = phaseHigh_q;
    phaseEn_d = phaseEn_q;
    alarmLimit_d = alarmLimit_q;
    alarmFill_d = alarmFill_q;
    samplePoint_d = samplePoint_q;
    masterMode_d = masterMode_q;
    irqMask_d = irqMask_q;
    events = 4'h0;
    if (write && accessDone && byteenable[0]) begin
      unique case (wordIndex)
        IDX_PHASE_LOW: begin
          phaseLow_d = writedata[7:0]; // R2
          events[EV_PHASE] = 1'b1;
        end
        IDX_PHASE_HIGH: begin
          phaseHigh_d = writedata[PH_HI_LSB +: 2]; // R2
          phaseEn_d = writedata[PH_EN_BIT]; // R3
          events[EV_PHASE] = 1'b1;
        end
        IDX_ALARM_LIMIT: begin
          alarmLimit_d = writedata[LIM_LSB +: 3]; // R4
          alarmFill_d = writedata[FILL_LSB +: 4];
          events[EV_ALARM] = 1'b1;
          // A wrong fill pattern is flagged, since the monitor misbehaves without it.
          events[EV_FILL] = (writedata[FILL_LSB +: 4] != LIM_FILL); // R5
        end
        IDX_SAMPLE_POINT: begin
          samplePoint_d = writedata[SMP_LSB +: 2]; // R6
          events[EV_SAMPLE] = 1'b1;
        end
        IDX_IRQ_MASK: begin
          irqMask_d = writedata[3:0];
        end
        IDX_DEVICE_CTRL: begin
          masterMode_d = writedata[MASTER_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Status bits are sticky; a new event wins over a write-one clear in the same cycle.
  always_comb begin
    irqStatus_d = irqStatus_q;
    if (write && accessDone && byteenable[0] && wordIndex == IDX_IRQ_STATUS) begin
      irqStatus_d = irqStatus_q & ~writedata[3:0];
    end
    irqStatus_d = irqStatus_d | events;
    irq_d = |(irqStatus_d & irqMask_d);
  end

  // ----------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------

  // Reserved bits read zero; unmapped words read zero as well.
  always_comb begin
    readdata_d = readdata_q;
    if (read && waitrequest_q) begin
      readdata_d = 32'h0000_0000;
      unique case (wordIndex)
        IDX_PHASE_LOW: readdata_d[7:0] = phaseLow_q; // R2
        IDX_PHASE_HIGH: readdata_d[7:0] = {phaseEn_q, 5'h00, phaseHigh_q}; // R7
        IDX_ALARM_LIMIT: readdata_d[7:0] = {1'b0, alarmLimit_q, alarmFill_q};
        IDX_SAMPLE_POINT: readdata_d[7:0] = {6'h00, samplePoint_q};
        IDX_IRQ_STATUS: readdata_d[3:0] = irqStatus_q;
        IDX_IRQ_MASK: readdata_d[3:0] = irqMask_q;
        IDX_DEVICE_CTRL: readdata_d[0] = masterMode_q;
        default: readdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------

  // Every state bit takes a fixed constant at reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phaseLow_q <= PH_LOW_RST;
      phaseHigh_q <= PH_HIGH_RST;
      phaseEn_q <= PH_EN_RST; // R3
      alarmLimit_q <= LIM_RST; // R4
      alarmFill_q <= LIM_FILL;
      samplePoint_q <= SMP_RST; // R6
      masterMode_q <= 1'b0;
      irqStatus_q <= IRQ_RST;
      irqMask_q <= IRQ_RST;
      readdata_q <= 32'h0000_0000;
      waitrequest_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      phaseLow_q <= phaseLow_d;
      phaseHigh_q <= phaseHigh_d;
      phaseEn_q <= phaseEn_d;
      alarmLimit_q <= alarmLimit_d;
      alarmFill_q <= alarmFill_d;
      samplePoint_q <= samplePoint_d;
      masterMode_q <= masterMode_d;
      irqStatus_q <= irqStatus_d;
      irqMask_q <= irqMask_d;
      readdata_q <= readdata_d;
      waitrequest_q <= waitrequest_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Decoded configuration.
  // ----------------------------------------------------------------

  assign cfgBus.phaseShiftValue = {phaseHigh_q, phaseLow_q}; // R2
  assign cfgBus.phaseShiftEnable = phaseEn_q;
  assign cfgBus.masterMode = masterMode_q;
  assign cfgBus.alarmLimitCode = alarmLimit_q;
  assign cfgBus.samplePointCode = samplePoint_q;

  posc_cfg_decode decodeInst (
    .cfg(cfgBus.decode)
  );

  // Outputs are registered so the datapath sees clean, glitch-free settings.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      offset_q <= 11'sh000;
      limitUi_q <= {1'b0, LIM_RST} + 4'h1;
      shift_q <= 3'sh0;
    end else begin
      offset_q <= cfgBus.appliedOffset; // R1
      limitUi_q <= cfgBus.alarmLimitUi; // R4
      shift_q <= cfgBus.sampleShiftHalfUi; // R6
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign irq = irq_q;
  assign appliedOffset = offset_q;
  assign alarmLimitUi = limitUi_q;
  assign sampleShiftHalfUi = shift_q;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------

  chk_offset_sign: assert property (@(posedge clock) disable iff (!rst_n) // R1
    (!masterMode_q || phaseEn_q)
    |=> offset_q == $signed({$past(phaseHigh_q[1]), $past(phaseHigh_q), $past(phaseLow_q)}))
    else $error("applied offset does not follow stored value");

  chk_high_pair: assert property (@(posedge clock) disable iff (!rst_n) // R2
    (write && accessDone && byteenable[0] && wordIndex == IDX_PHASE_HIGH) |=> phaseHigh_q == $past(writedata[1:0]))
    else $error("upper phase bits not stored");

  chk_master_gate: assert property (@(posedge clock) disable iff (!rst_n) // R3
    (masterMode_q && !phaseEn_q) |=> offset_q == 11'sh000)
    else $error("offset applied while disabled in master mode");

  chk_limit_map: assert property (@(posedge clock) disable iff (!rst_n) // R4
    ##1 limitUi_q == {1'b0, $past(alarmLimit_q)} + 4'h1)
    else $error("alarm limit mapping wrong");

  chk_fill_flag: assert property (@(posedge clock) disable iff (!rst_n) // R5
    (write && accessDone && byteenable[0] && wordIndex == IDX_ALARM_LIMIT && writedata[3:0] != LIM_FILL)
    |=> irqStatus_q[EV_FILL])
    else $error("bad fill pattern not flagged");

  chk_sample_late: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (samplePoint_q == 2'h2) |=> shift_q == 3'sh2)
    else $error("one UI late not decoded");

  chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n) // R7
    (read && waitrequest_q && wordIndex == IDX_PHASE_HIGH) |=> readdata_q[6:2] == 5'h00)
    else $error("reserved bits read non-zero");

  chk_wait_answer: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(read) |-> ##1 !waitrequest_q)
    else $error("read not answered in one cycle");

  chk_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 irq_q == |($past(irqStatus_d) & $past(irqMask_d)))
    else $error("interrupt level wrong");

  // Each field keeps exactly the bits of an accepted write.
  chk_low_store: assert property (@(posedge clock) disable iff (!rst_n) // R2
    (write && accessDone && byteenable[0] && wordIndex == IDX_PHASE_LOW)
    |=> phaseLow_q == $past(writedata[7:0]))
    else $error("lower phase bits not stored");

  chk_enable_store: assert property (@(posedge clock) disable iff (!rst_n) // R3
    (write && accessDone && byteenable[0] && wordIndex == IDX_PHASE_HIGH)
    |=> phaseEn_q == $past(writedata[PH_EN_BIT]))
    else $error("phase enable bit not stored");

  chk_limit_store: assert property (@(posedge clock) disable iff (!rst_n) // R4
    (write && accessDone && byteenable[0] && wordIndex == IDX_ALARM_LIMIT)
    |=> alarmLimit_q == $past(writedata[LIM_LSB +: 3]))
    else $error("alarm limit code not stored");

  chk_sample_store: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (write && accessDone && byteenable[0] && wordIndex == IDX_SAMPLE_POINT)
    |=> samplePoint_q == $past(writedata[SMP_LSB +: 2]))
    else $error("sample point code not stored");

  // A write whose data lane is off must leave every setting alone.
  chk_lane_refused: assert property (@(posedge clock) disable iff (!rst_n)
    (write && accessDone && !byteenable[0])
    |=> $stable(phaseLow_q) && $stable(phaseHigh_q) && $stable(phaseEn_q)
        && $stable(alarmLimit_q) && $stable(samplePoint_q))
    else $error("write with data lane off changed a setting");

  // The other sample codes; a wrong sign would move the sync point the wrong way.
  chk_sample_early: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (samplePoint_q == 2'h1) |=> shift_q == -3'sh1)
    else $error("half UI early not decoded");

  chk_sample_half: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (samplePoint_q == 2'h3) |=> shift_q == 3'sh1)
    else $error("half UI late not decoded");

  chk_sample_target: assert property (@(posedge clock) disable iff (!rst_n) // R6
    (samplePoint_q == 2'h0) |=> shift_q == 3'sh0)
    else $error("on target not decoded");

  // Bus side: unmapped words and the upper data lanes always read zero.
  chk_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
    (read && waitrequest_q && !addrHit) |=> readdata_q == 32'h0000_0000)
    else $error("unmapped word read non-zero");

  chk_upper_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (read && waitrequest_q) |=> readdata_q[31:8] == 24'h000000)
    else $error("upper read lanes non-zero");

  chk_wait_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    !waitrequest_q |=> waitrequest_q)
    else $error("waitrequest low for more than one cycle");

  // Status bits only fall through a write-one clear to the status word.
  chk_status_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    !(write && accessDone && byteenable[0] && wordIndex == IDX_IRQ_STATUS)
    |=> (irqStatus_q & $past(irqStatus_q)) == $past(irqStatus_q))
    else $error("status bit lost without a clear");

endmodule : posc_regs

// ===== testbench/posc_regs_tb_top.sv
// Self-checking testbench for the phase offset and sync configuration register bank.
`timescale 1ns/1ps
module posc_regs_tb_top;
  import posc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic signed [10:0] appliedOffset;
  logic [3:0] alarmLimitUi;
  logic signed [2:0] sampleShiftHalfUi;
  logic [10:0] smpExp [4] = '{11'h000, 11'h7FF, 11'h002, 11'h001};
  int badCount = 0;
  int totalChecks = 0;
  int cycleCount = 0;

  // ----------------------------------------------------------------
  // Device under test, clock and hang guard.
  // ----------------------------------------------------------------
  posc_regs uut (.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .appliedOffset(appliedOffset), .alarmLimitUi(alarmLimitUi),
    .sampleShiftHalfUi(sampleShiftHalfUi));

  // Half period of the 25 MHz clock.
  always #(CLOCK_PERIOD_NS / 2) clock = ~clock;

  // The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      badCount++;
      finishTest();
    end
  end

  // ----------------------------------------------------------------
  // Reporting and comparison.
  // ----------------------------------------------------------------
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finishTest

  // Compares a word read over the register bus.
  task automatic chkReg(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chkReg

  // Compares a decoded output port, widened to eleven bits.
  task automatic chkPort(input string name, input logic [10:0] exp, input logic [10:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chkPort

  // ----------------------------------------------------------------
  // Avalon-MM master cycles.
  // ----------------------------------------------------------------
  // Waitrequest and readdata are sampled at the rising edge, before that edge's own updates land.
  // No wait length is assumed; only the hang guard ends a wait that never finishes.
  task automatic busCycle(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be,
                          output logic [31:0] rd);
    @(posedge clock);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : busCycle

  // Writes one register and waits until the decoded outputs have followed.
  task automatic regWrite(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    busCycle(1'b1, idx, wd, 4'hF, rd);
    repeat (2) @(negedge clock);
  endtask : regWrite

  // Reads one register; reserved bits are masked off because software ignores them on read.
  task automatic regRead(input string name, input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    logic [31:0] rd;
    busCycle(1'b0, idx, 8'h00, 4'hF, rd);
    chkReg(name, {24'h000000, exp & mask}, rd & {24'h000000, mask});
  endtask : regRead

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic testReset();
    regRead("phase low", IDX_PHASE_LOW, 8'hFF, 8'h00);
    regRead("phase high", IDX_PHASE_HIGH, 8'h83, 8'h00);
    regRead("alarm limit", IDX_ALARM_LIMIT, 8'h70, 8'h20);
    regRead("sample point", IDX_SAMPLE_POINT, 8'h03, 8'h00);
    chkPort("alarm ui", 11'h003, {7'h00, alarmLimitUi});
    chkPort("offset", 11'h000, appliedOffset);
  endtask : testReset

  // Extreme values, then master mode with the enable off and on.
  task automatic testPhase();
    regWrite(IDX_PHASE_LOW, 8'h00);
    regWrite(IDX_PHASE_HIGH, 8'h02);
    chkPort("offset", 11'h600, appliedOffset);
    regRead("phase high", IDX_PHASE_HIGH, 8'h83, 8'h02);
    regWrite(IDX_PHASE_LOW, 8'hFF);
    regWrite(IDX_PHASE_HIGH, 8'h01);
    chkPort("offset", 11'h1FF, appliedOffset);
    regRead("phase low", IDX_PHASE_LOW, 8'hFF, 8'hFF);
    regWrite(IDX_DEVICE_CTRL, 8'h01);
    chkPort("offset", 11'h000, appliedOffset);
    regWrite(IDX_PHASE_HIGH, 8'h81);
    chkPort("offset", 11'h1FF, appliedOffset);
    regRead("phase high", IDX_PHASE_HIGH, 8'h83, 8'h81);
    regWrite(IDX_DEVICE_CTRL, 8'h00);
  endtask : testPhase

  // Every alarm limit code, always with the fixed low nibble.
  task automatic testAlarm();
    for (int i = 0; i < 8; i++) begin
      regWrite(IDX_ALARM_LIMIT, {1'b0, 3'(i), 4'hB});
      chkPort("alarm ui", 11'(i + 1), {7'h00, alarmLimitUi});
      regRead("alarm limit", IDX_ALARM_LIMIT, 8'h70, {1'b0, 3'(i), 4'h0});
    end
  endtask : testAlarm

  // Every sampling point code.
  task automatic testSample();
    for (int i = 0; i < 4; i++) begin
      regWrite(IDX_SAMPLE_POINT, {6'h00, 2'(i)});
      chkPort("sample shift", smpExp[i], {{8{sampleShiftHalfUi[2]}}, sampleShiftHalfUi});
    end
  endtask : testSample

  // Sticky status, masking and write-one-to-clear.
  task automatic testIrq();
    regWrite(IDX_IRQ_MASK, 8'h00);
    regWrite(IDX_IRQ_STATUS, 8'h0F);
    regRead("status", IDX_IRQ_STATUS, 8'h0F, 8'h00);
    regWrite(IDX_ALARM_LIMIT, 8'h20);
    regRead("status", IDX_IRQ_STATUS, 8'h0F, 8'h0A);
    chkPort("irq", 11'h000, {10'h000, irq});
    regWrite(IDX_IRQ_MASK, 8'h08);
    chkPort("irq", 11'h001, {10'h000, irq});
    regWrite(IDX_IRQ_STATUS, 8'h08);
    chkPort("irq", 11'h000, {10'h000, irq});
    regRead("status", IDX_IRQ_STATUS, 8'h0F, 8'h02);
    regWrite(IDX_ALARM_LIMIT, 8'h2B);
  endtask : testIrq

  // An unmapped place, and a write with its byte lane disabled; the sample code is still 3 from before.
  task automatic testRefused();
    logic [31:0] rd;
    regWrite(8'h10, 8'h55);
    regRead("unmapped", 8'h10, 8'hFF, 8'h00);
    busCycle(1'b1, IDX_SAMPLE_POINT, 8'h01, 4'h0, rd);
    regRead("sample point", IDX_SAMPLE_POINT, 8'h03, 8'h03);
  endtask : testRefused

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    testReset();
    testPhase();
    testAlarm();
    testSample();
    testIrq();
    testRefused();
    finishTest();
  end
endmodule : posc_regs_tb_top
